// *** hw/otfm_params.svh ***
`ifndef OTFM_PARAMS_SVH
`define OTFM_PARAMS_SVH

// command codes
`define OTFM_CMD_CLEAR_FAULTS 8'h03
`define OTFM_CMD_OC_WARN      8'h4A
`define OTFM_CMD_OT_FAULT     8'h4F
`define OTFM_CMD_OT_ACTION    8'h50
`define OTFM_CMD_OT_WARN      8'h51
`define OTFM_CMD_STATUS_BYTE  8'h78
`define OTFM_CMD_STATUS_TEMP  8'h7D
`define OTFM_CMD_STATUS_CML   8'h7E
`define OTFM_PHASE_ALL        8'hFF

// word and byte fields
`define OTFM_EXP_HI   15
`define OTFM_EXP_LO   11
`define OTFM_MAN_HI   10
`define OTFM_ACT_HI   7
`define OTFM_ACT_LO   6
`define OTFM_RETRY_HI 5
`define OTFM_RETRY_LO 3
`define OTFM_DELAY_HI 2
`define OTFM_DELAY_LO 0

// status bit positions
`define OTFM_SB_TEMP      2
`define OTFM_SB_CML       1
`define OTFM_ST_OTF       7
`define OTFM_ST_OTW       6
`define OTFM_CML_BAD_CMD  7
`define OTFM_CML_BAD_DATA 6

// reset values
`define OTFM_OC_WARN_RST   16'hF0C8
`define OTFM_OT_FAULT_RST  16'h007D
`define OTFM_OT_ACTION_RST 8'h80
`define OTFM_OT_WARN_RST   16'h0069

// Q8 fixed point limits
`define OTFM_Q8_FRAC      6'sh08
`define OTFM_Q8_SAT_SH    6'sh14
`define OTFM_Q8_SAT_POS   32'sh7FFF_FFFF
`define OTFM_Q8_SAT_NEG   32'sh8000_0000
`define OTFM_Q8_TEMP_OFF  32'sh0000_FF00
`define OTFM_Q8_HYST      32'sh0000_1400
`define OTFM_Q8_OC_MIN    32'sh0000_0800
`define OTFM_Q8_OC_MAX    32'sh0000_3E00
`define OTFM_Q8_STEP_RND  32'sh0000_01FF
`define OTFM_Q8_STEP_SH   9
`define OTFM_Q8_QTR_RND   32'sh0000_0020
`define OTFM_Q8_QTR_SH    6
`define OTFM_Q8_DEG_RND   32'sh0000_0080
`define OTFM_Q8_DEG_SH    8
`define OTFM_OC_MIN_AMPS  6'h08
`define OTFM_OC_MAX_AMPS  6'h3E
`define OTFM_QTR_MAX      32'sh0000_00F8
`define OTFM_DEG_MAX      32'sh0000_00A0
`define OTFM_EXP_QUARTER  5'h1E
`define OTFM_EXP_UNIT     5'h00

// retry codes and timing
`define OTFM_RETRY_NONE    3'h0
`define OTFM_RETRY_FOREVER 3'h7
`define OTFM_SYS_CLK_NS    20
`define OTFM_MS_NS         1000000
`define OTFM_LONG_DELAY_MS 16'h000A
`define OTFM_PRE_W         20

`endif

// *** hw/otfm_pkg.sv ***
`include "otfm_params.svh"

package otfm_pkg;

	typedef struct packed {
		logic        write;
		logic [7:0]  code;
		logic [15:0] data;
	} otfm_cmd_s;

	typedef struct packed {
		logic        error;
		logic [15:0] data;
	} otfm_rsp_s;

	typedef enum logic [2:0] {
		ST_OFF    = 3'b000,
		ST_RUN    = 3'b001,
		ST_DELAY  = 3'b010,
		ST_COOL   = 3'b011,
		ST_RESTART_WAIT_PERIOD = 3'b100,
		ST_LATCH  = 3'b101,
		ST_STUCK  = 3'b110
	} otfm_state_e;

	typedef enum logic [1:0] {
		ACT_IGNORE     = 2'b00,
		ACT_DELAYED    = 2'b01,
		ACT_IMMEDIATE  = 2'b10,
		ACT_COOL_RETRY = 2'b11
	} otfm_action_e;

	typedef struct packed {
		logic        ready;
		logic        reqTgl;
		otfm_cmd_s   req;
		logic [2:0]  ackSync;
		logic        ackSeen;
		logic        rspValid;
		otfm_rsp_s   rsp;
	} otfm_link_s;

	typedef struct packed {
		logic [2:0]             reqSync;
		logic                   reqSeen;
		logic                   ackTgl;
		otfm_rsp_s              ackPayload;
		logic [15:0]            ocWarn;
		logic [15:0]            otFault;
		logic [7:0]             otAction;
		logic [15:0]            otWarn;
		logic [7:0]             statusTemp;
		logic [7:0]             statusCml;
		logic                   hostAlert;
		otfm_state_e            state;
		logic [`OTFM_PRE_W-1:0] pre;
		logic [15:0]            msLeft;
		logic [2:0]             attempts;
		logic                   enPrev;
		logic [2:0]             dieSync;
		logic                   dieHot;
		logic                   converterRun;
		logic [5:0]             ocStep;
	} otfm_core_s;

endpackage

// *** hw/otfm_link_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "otfm_params.svh"

module otfm_link_port (
	// link clock and raw reset
	input  wire logic                linkClk,
	input  wire logic                rst_n,
	// command link
	input  wire logic                cmdValid,
	input  wire otfm_pkg::otfm_cmd_s cmd,
	output logic                     cmdReady,
	output logic                     rspValid,
	output otfm_pkg::otfm_rsp_s      rsp,
	// crossing to the system clock
	output logic                     reqTgl,
	output otfm_pkg::otfm_cmd_s      reqPayload,
	input  wire logic                ackTgl,
	input  wire otfm_pkg::otfm_rsp_s ackPayload
);
	import otfm_pkg::*;

	localparam otfm_link_s LINK_RST = '{ready: 1'b1, default: '0};

	logic [1:0] linkRstPipe;
	logic       linkRst_n;
	otfm_link_s link;
	otfm_link_s next_link;

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			linkRstPipe <= 2'h0;
		end else begin
			linkRstPipe <= {linkRstPipe[0], 1'b1};
		end
	end
	assign linkRst_n = linkRstPipe[1];

	// payload frozen in flight, so late sampling is safe
	always_comb begin
		next_link = link;
		next_link.rspValid = 1'b0;
		next_link.ackSync = {link.ackSync[1:0], ackTgl};
		if (link.ready && cmdValid) begin
			next_link.req = cmd;
			next_link.reqTgl = ~link.reqTgl;
			next_link.ready = 1'b0;
		end
		if (link.ackSync[1] == link.ackSync[2] && link.ackSync[2] != link.ackSeen) begin
			next_link.ackSeen = link.ackSync[2];
			next_link.rspValid = 1'b1;
			next_link.rsp = ackPayload;
			next_link.ready = 1'b1;
		end
	end

	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			link <= LINK_RST;
		end else begin
			link <= next_link;
		end
	end

	assign cmdReady = link.ready;
	assign rspValid = link.rspValid;
	assign rsp = link.rsp;
	assign reqTgl = link.reqTgl;
	assign reqPayload = link.req;

endmodule // otfm_link_port

`default_nettype wire

// *** hw/otfm_fault_manager.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "otfm_params.svh"

// Summary of operation
// RULE_01: current warn hardware steps 8..62 A by 2
// RULE_02: off-step current limit rounds up one step
// RULE_03: current limit below 8 A enforced as 8
// RULE_04: reload rounds current limit to 0.25 A, max 62
// RULE_05: current limit valid up to 62 A per phase
// RULE_06: limits are linear words, current exponent resets 11110b
// RULE_07: per-phase current limit drives that phase's hardware
// RULE_08: fault temperature accepted at full linear resolution
// RULE_09: reload rounds temperature limit to whole degree 0..160
// RULE_10: fault limit 255 disables compare, die shutdown stays
// RULE_11: unsupported write refused, invalid-data flagged, host alerted
// RULE_12: fault sets temp summary and fault flag, alerts host
// RULE_13: fault releases once temperature below warn limit
// RULE_14: warn above fault means release at fault minus 20
// RULE_15: action code picks ignore, delayed, immediate or cool-retry
// RULE_16: retry count latches, limits or repeats restarts
// RULE_17: delay code sets shutdown delay and restart_wait_period length
// RULE_18: clear during cool band may stick until hot or re-enable
// RULE_19: enable refused while fault present, even when ignoring
// RULE_20: host should set fault limit above start-up temperature
// RULE_21: warning sets temp summary and warn flag, alerts host

module otfm_fault_manager #(
	parameter int MS_CYCLES = `OTFM_MS_NS / `OTFM_SYS_CLK_NS
) (
	// clocks and reset
	input  wire logic                sys_clk,
	input  wire logic                linkClk,
	input  wire logic                rst_n,
	// command link, link clock
	input  wire logic                cmdValid,
	input  wire otfm_pkg::otfm_cmd_s cmd,
	output logic                     cmdReady,
	output logic                     rspValid,
	output otfm_pkg::otfm_rsp_s      rsp,
	// converter context, system clock
	input  wire logic                outputEnable,
	input  wire logic                startupDone,
	input  wire logic                nvmReload,
	input  wire logic [15:0]         tempReading,
	input  wire logic [7:0]          phaseSelect,
	input  wire logic [2:0]          phaseCount,
	input  wire logic [7:0]          softStartRiseMs,
	// on-die thermal shutdown pin
	input  wire logic                dieOverTemp,
	// converter control and status
	output logic                     converterRun,
	output logic [5:0]               ocPhaseStep,
	output logic                     hostAlert,
	output logic                     tempFaultFlag,
	output logic                     tempWarnFlag
);
	import otfm_pkg::*;

	localparam int PW = `OTFM_PRE_W;
	localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);
	localparam otfm_core_s CORE_RST = '{
		ocWarn: `OTFM_OC_WARN_RST,
		otFault: `OTFM_OT_FAULT_RST,
		otAction: `OTFM_OT_ACTION_RST,
		otWarn: `OTFM_OT_WARN_RST,
		state: ST_OFF,
		ocStep: `OTFM_OC_MAX_AMPS,
		default: '0
	};

	if (MS_CYCLES < 2 || MS_CYCLES >= (1 << PW)) begin : g_bad_ms
		$error("MS_CYCLES out of range");
	end

	logic [1:0] sysRstPipe;
	logic       sysRst_n;
	logic       linkReqTgl;
	otfm_cmd_s  reqPayload;
	otfm_core_s core;
	otfm_core_s next_core;

	// linear word to Q8, saturating
	function automatic logic signed [31:0] linToQ8(input logic [15:0] w);
		logic signed [31:0] m;
		logic signed [5:0]  sh;
		m = 32'(signed'(w[`OTFM_MAN_HI:0]));
		sh = 6'(signed'(w[`OTFM_EXP_HI:`OTFM_EXP_LO])) + `OTFM_Q8_FRAC;
		if (sh > `OTFM_Q8_SAT_SH) begin
			linToQ8 = m[31] ? `OTFM_Q8_SAT_NEG : `OTFM_Q8_SAT_POS;
		end else if (sh >= 0) begin
			linToQ8 = m <<< sh[4:0];
		end else begin
			linToQ8 = m >>> 5'(-sh);
		end
	endfunction

	function automatic logic [5:0] stepAmps(input logic signed [31:0] q);
		logic signed [31:0] halves;
		halves = (q + `OTFM_Q8_STEP_RND) >>> `OTFM_Q8_STEP_SH;
		if (q <= `OTFM_Q8_OC_MIN) begin
			stepAmps = `OTFM_OC_MIN_AMPS; // RULE_03
		end else if (q >= `OTFM_Q8_OC_MAX) begin
			stepAmps = `OTFM_OC_MAX_AMPS; // RULE_01
		end else begin
			stepAmps = {halves[4:0], 1'b0}; // RULE_02
		end
	endfunction

	function automatic logic [15:0] roundTemp(input logic signed [31:0] q);
		logic signed [31:0] deg;
		deg = (q + `OTFM_Q8_DEG_RND) >>> `OTFM_Q8_DEG_SH;
		if (deg < 0) begin
			deg = '0;
		end else if (deg > `OTFM_DEG_MAX) begin
			deg = `OTFM_DEG_MAX;
		end
		roundTemp = {`OTFM_EXP_UNIT, deg[`OTFM_MAN_HI:0]}; // RULE_09
	endfunction

	function automatic logic [15:0] hiccupMs(input logic [2:0] code, input logic [7:0] rise);
		logic [2:0] mult;
		if (code == 3'h0) begin
			mult = 3'h1;
		end else if (code <= 3'h2) begin
			mult = 3'h2;
		end else if (code == 3'h3) begin
			mult = 3'h3;
		end else begin
			mult = 3'h4;
		end
		hiccupMs = 16'(rise) * 16'(mult); // RULE_17
	endfunction

	function automatic otfm_state_e afterShutdown(input logic [2:0] retry,
		input logic [2:0] attempts);
		if (retry == `OTFM_RETRY_NONE) begin
			afterShutdown = ST_LATCH;
		end else if (retry != `OTFM_RETRY_FOREVER && attempts >= retry) begin
			afterShutdown = ST_LATCH;
		end else begin
			afterShutdown = ST_RESTART_WAIT_PERIOD;
		end
	endfunction

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysRstPipe <= 2'h0;
		end else begin
			sysRstPipe <= {sysRstPipe[0], 1'b1};
		end
	end
	assign sysRst_n = sysRstPipe[1];

	otfm_link_port u_link (
		.linkClk    (linkClk),
		.rst_n      (rst_n),
		.cmdValid   (cmdValid),
		.cmd        (cmd),
		.cmdReady   (cmdReady),
		.rspValid   (rspValid),
		.rsp        (rsp),
		.reqTgl     (linkReqTgl),
		.reqPayload (reqPayload),
		.ackTgl     (core.ackTgl),
		.ackPayload (core.ackPayload)
	);

	always_comb begin
		logic signed [31:0] tempQ;
		logic signed [31:0] faultQ;
		logic signed [31:0] warnQ;
		logic signed [31:0] releaseQ;
		logic signed [31:0] wq;
		logic signed [31:0] ocLimitQ;
		logic signed [31:0] qtr;
		logic [7:0]         sb;
		logic [2:0]         retry;
		logic [2:0]         delayCode;
		logic               faultDet;
		logic               warnDet;
		logic               releaseOk;
		logic               reqEvt;
		logic               clearCmd;
		logic               badData;
		logic               badCmd;
		logic               msTick;
		logic               enRise;
		next_core = core;
		tempQ = linToQ8(tempReading);
		faultQ = linToQ8(core.otFault); // RULE_08
		warnQ = linToQ8(core.otWarn);
		wq = linToQ8(reqPayload.data); // RULE_06
		ocLimitQ = $signed(32'(phaseCount)) * `OTFM_Q8_OC_MAX;
		qtr = '0;
		retry = core.otAction[`OTFM_RETRY_HI:`OTFM_RETRY_LO];
		delayCode = core.otAction[`OTFM_DELAY_HI:`OTFM_DELAY_LO];
		faultDet = faultQ != `OTFM_Q8_TEMP_OFF && tempQ > faultQ; // RULE_10
		warnDet = warnQ != `OTFM_Q8_TEMP_OFF && tempQ > warnQ;
		// disabled warn limit also counts as above the fault limit
		if (warnQ == `OTFM_Q8_TEMP_OFF || warnQ > faultQ) begin
			releaseQ = faultQ - `OTFM_Q8_HYST; // RULE_14
		end else begin
			releaseQ = warnQ; // RULE_13
		end
		releaseOk = tempQ < releaseQ; // RULE_13
		reqEvt = core.reqSync[1] == core.reqSync[2] && core.reqSync[2] != core.reqSeen;
		clearCmd = 1'b0;
		badData = 1'b0;
		badCmd = 1'b0;
		msTick = core.pre == PRE_LAST;
		enRise = outputEnable && !core.enPrev;
		sb = 8'h00;
		sb[`OTFM_SB_TEMP] = |core.statusTemp;
		sb[`OTFM_SB_CML] = |core.statusCml;

		next_core.reqSync = {core.reqSync[1:0], linkReqTgl};
		next_core.dieSync = {core.dieSync[1:0], dieOverTemp};
		if (core.dieSync[1] == core.dieSync[2]) begin
			next_core.dieHot = core.dieSync[2];
		end
		next_core.enPrev = outputEnable;
		next_core.pre = msTick ? '0 : core.pre + 1'b1;

		// one command per toggle; answer is held until the next one
		if (reqEvt) begin
			next_core.reqSeen = core.reqSync[2];
			next_core.ackTgl = ~core.ackTgl;
			next_core.ackPayload = '0;
			if (reqPayload.code == `OTFM_CMD_CLEAR_FAULTS && reqPayload.write) begin
				clearCmd = 1'b1;
			end else if (reqPayload.code == `OTFM_CMD_OC_WARN) begin
				if (!reqPayload.write) begin
					next_core.ackPayload.data = core.ocWarn;
				end else if (wq >= 0 && wq <= ocLimitQ) begin // RULE_05
					next_core.ocWarn = reqPayload.data;
					if (phaseSelect != `OTFM_PHASE_ALL) begin
						next_core.ocStep = stepAmps(wq); // RULE_07
					end
				end else begin
					badData = 1'b1;
				end
			end else if (reqPayload.code == `OTFM_CMD_OT_FAULT) begin
				if (!reqPayload.write) begin
					next_core.ackPayload.data = core.otFault;
				end else if (wq >= 0 && wq <= `OTFM_Q8_TEMP_OFF) begin
					next_core.otFault = reqPayload.data; // RULE_08
				end else begin
					badData = 1'b1;
				end
			end else if (reqPayload.code == `OTFM_CMD_OT_ACTION) begin
				if (!reqPayload.write) begin
					next_core.ackPayload.data = {8'h00, core.otAction};
				end else begin
					next_core.otAction = reqPayload.data[7:0];
				end
			end else if (reqPayload.code == `OTFM_CMD_OT_WARN) begin
				if (!reqPayload.write) begin
					next_core.ackPayload.data = core.otWarn;
				end else if (wq >= 0 && wq <= `OTFM_Q8_TEMP_OFF) begin
					next_core.otWarn = reqPayload.data;
				end else begin
					badData = 1'b1;
				end
			end else if (reqPayload.code == `OTFM_CMD_STATUS_BYTE && !reqPayload.write) begin
				next_core.ackPayload.data = {8'h00, sb};
			end else if (reqPayload.code == `OTFM_CMD_STATUS_TEMP && !reqPayload.write) begin
				next_core.ackPayload.data = {8'h00, core.statusTemp};
			end else if (reqPayload.code == `OTFM_CMD_STATUS_CML && !reqPayload.write) begin
				next_core.ackPayload.data = {8'h00, core.statusCml};
			end else begin
				badCmd = 1'b1;
			end
			next_core.ackPayload.error = badData || badCmd; // RULE_11
		end

		// reload snaps limits to the stored grid
		if (nvmReload) begin
			qtr = (linToQ8(core.ocWarn) + `OTFM_Q8_QTR_RND) >>> `OTFM_Q8_QTR_SH;
			if (qtr < 0) begin
				qtr = '0;
			end else if (qtr > `OTFM_QTR_MAX) begin
				qtr = `OTFM_QTR_MAX;
			end
			next_core.ocWarn = {`OTFM_EXP_QUARTER, qtr[`OTFM_MAN_HI:0]}; // RULE_04
			next_core.ocStep = stepAmps(qtr <<< `OTFM_Q8_QTR_SH);
			next_core.otFault = roundTemp(faultQ); // RULE_09
			next_core.otWarn = roundTemp(warnQ);
		end

		// clear first so a same-cycle event still lands
		if (clearCmd) begin
			next_core.statusTemp = 8'h00;
			next_core.statusCml = 8'h00;
		end
		if (faultDet) begin
			next_core.statusTemp[`OTFM_ST_OTF] = 1'b1; // RULE_12
		end
		if (warnDet) begin
			next_core.statusTemp[`OTFM_ST_OTW] = 1'b1; // RULE_21
		end
		if (badData) begin
			next_core.statusCml[`OTFM_CML_BAD_DATA] = 1'b1; // RULE_11
		end
		if (badCmd) begin
			next_core.statusCml[`OTFM_CML_BAD_CMD] = 1'b1;
		end
		next_core.hostAlert = |next_core.statusTemp || |next_core.statusCml; // RULE_12

		if ((core.state == ST_DELAY || core.state == ST_RESTART_WAIT_PERIOD) && msTick
			&& core.msLeft != 16'h0000) begin
			next_core.msLeft = core.msLeft - 16'h0001;
		end

		case (core.state)
			ST_OFF: begin
				if (enRise && !faultDet) begin // RULE_19
					next_core.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (faultDet) begin
					case (otfm_action_e'(core.otAction[`OTFM_ACT_HI:`OTFM_ACT_LO])) // RULE_15
						ACT_IGNORE: begin
							next_core.state = ST_RUN;
						end
						ACT_DELAYED: begin
							next_core.state = ST_DELAY;
							next_core.msLeft = (delayCode == 3'h0) ? `OTFM_LONG_DELAY_MS
								: 16'(delayCode); // RULE_17
						end
						ACT_IMMEDIATE: begin
							next_core.state = afterShutdown(retry, core.attempts); // RULE_16
							next_core.msLeft = hiccupMs(delayCode, softStartRiseMs);
						end
						default: begin
							next_core.state = ST_COOL;
						end
					endcase
				end
			end
			ST_DELAY: begin
				if (!faultDet) begin
					next_core.state = ST_RUN;
				end else if (core.msLeft == 16'h0000) begin
					next_core.state = afterShutdown(retry, core.attempts); // RULE_15
					next_core.msLeft = hiccupMs(delayCode, softStartRiseMs);
				end
			end
			ST_COOL: begin
				if (releaseOk) begin
					next_core.state = afterShutdown(retry, core.attempts); // RULE_13
					next_core.msLeft = hiccupMs(delayCode, softStartRiseMs);
				end else if (clearCmd && !faultDet) begin
					next_core.state = ST_STUCK; // RULE_18
				end
			end
			ST_RESTART_WAIT_PERIOD: begin
				if (core.msLeft == 16'h0000) begin
					if (core.attempts != `OTFM_RETRY_FOREVER) begin
						next_core.attempts = core.attempts + 3'h1;
					end
					// a hot attempt is counted and leaves the converter off
					if (warnDet) begin
						next_core.state = afterShutdown(retry, core.attempts + 3'h1); // RULE_16
						next_core.msLeft = hiccupMs(delayCode, softStartRiseMs);
					end else begin
						next_core.state = ST_RUN;
					end
				end
			end
			ST_STUCK: begin
				if (faultDet) begin
					next_core.state = ST_COOL; // RULE_18
				end
			end
			ST_LATCH: begin
				next_core.state = ST_LATCH;
			end
			default: begin
				next_core.state = ST_OFF;
			end
		endcase

		if (startupDone && core.state == ST_RUN) begin
			next_core.attempts = 3'h0; // RULE_16
		end
		if (!outputEnable) begin
			next_core.state = ST_OFF;
			next_core.attempts = 3'h0;
		end
		next_core.converterRun = (next_core.state == ST_RUN || next_core.state == ST_DELAY)
			&& !next_core.dieHot; // RULE_10
	end

	always_ff @(posedge sys_clk or negedge sysRst_n) begin
		if (!sysRst_n) begin
			core <= CORE_RST;
		end else begin
			core <= next_core;
		end
	end

	assign converterRun = core.converterRun;
	assign ocPhaseStep = core.ocStep;
	assign hostAlert = core.hostAlert;
	assign tempFaultFlag = core.statusTemp[`OTFM_ST_OTF];
	assign tempWarnFlag = core.statusTemp[`OTFM_ST_OTW];

endmodule // otfm_fault_manager

`default_nettype wire

// *** testbench/otfm_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module otfm_checker #(
	parameter int MS_CYCLES = 50000
) (
	// clocks and reset
	input wire logic       sys_clk,
	input wire logic       linkClk,
	input wire logic       rst_n,
	// link handshake
	input wire logic       cmdValid,
	input wire logic       cmdReady,
	input wire logic       rspValid,
	// converter side
	input wire logic       outputEnable,
	input wire logic       dieOverTemp,
	input wire logic       converterRun,
	input wire logic [5:0] ocPhaseStep,
	input wire logic       hostAlert,
	input wire logic       tempFaultFlag,
	input wire logic       tempWarnFlag
);
	property p_step_grid;
		@(posedge sys_clk) disable iff (!rst_n)
		ocPhaseStep >= 6'h08 && ocPhaseStep <= 6'h3E && !ocPhaseStep[0];
	endproperty
	a_step_grid: assert property (p_step_grid)
		else $error("step off grid");
	property p_fault_alert;
		@(posedge sys_clk) disable iff (!rst_n) $rose(tempFaultFlag) |-> ##[0:2] hostAlert;
	endproperty
	a_fault_alert: assert property (p_fault_alert)
		else $error("fault without alert");
	property p_warn_alert;
		@(posedge sys_clk) disable iff (!rst_n) $rose(tempWarnFlag) |-> ##[0:2] hostAlert;
	endproperty
	a_warn_alert: assert property (p_warn_alert)
		else $error("warning without alert");
	// allow for the three sync flops
	property p_die_off;
		@(posedge sys_clk) disable iff (!rst_n) dieOverTemp [*6] |-> !converterRun;
	endproperty
	a_die_off: assert property (p_die_off)
		else $error("run while die hot");
	property p_disable_off;
		@(posedge sys_clk) disable iff (!rst_n) $fell(outputEnable) |-> ##[0:3] !converterRun;
	endproperty
	a_disable_off: assert property (p_disable_off)
		else $error("run after disable");
	property p_run_needs_en;
		@(posedge sys_clk) disable iff (!rst_n) $rose(converterRun) |-> $past(outputEnable);
	endproperty
	a_run_needs_en: assert property (p_run_needs_en)
		else $error("run without enable");
	property p_rsp_bounded;
		@(posedge linkClk) disable iff (!rst_n)
		cmdValid && cmdReady |=> !cmdReady ##[2:20] rspValid;
	endproperty
	a_rsp_bounded: assert property (p_rsp_bounded)
		else $error("answer missing");
	property p_rsp_pulse;
		@(posedge linkClk) disable iff (!rst_n) rspValid |-> cmdReady ##1 !rspValid;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse)
		else $error("answer not one pulse");
endmodule // otfm_checker

bind otfm_fault_manager otfm_checker #(.MS_CYCLES(MS_CYCLES)) u_otfm_checker (
	.sys_clk(sys_clk), .linkClk(linkClk), .rst_n(rst_n), .cmdValid(cmdValid),
	.cmdReady(cmdReady), .rspValid(rspValid), .outputEnable(outputEnable),
	.dieOverTemp(dieOverTemp), .converterRun(converterRun), .ocPhaseStep(ocPhaseStep),
	.hostAlert(hostAlert), .tempFaultFlag(tempFaultFlag), .tempWarnFlag(tempWarnFlag)
);

`default_nettype wire

// *** testbench/otfm_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module otfm_host_model (
	// link from the device
	input  wire logic                linkClk,
	input  wire logic                cmdReady,
	input  wire logic                rspValid,
	input  wire otfm_pkg::otfm_rsp_s rsp,
	// request to the device
	output var logic                 cmdValid,
	output otfm_pkg::otfm_cmd_s      cmd
);
	import otfm_pkg::*;
	initial begin
		cmdValid = 1'b0;
		cmd = '0;
	end
	// idle bus churns so stale data never looks valid
	always @(posedge linkClk) if (!cmdValid) cmd <= ~cmd;
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
		input int gap, output otfm_rsp_s r);
		int n;
		repeat (gap) @(posedge linkClk);
		#1;
		cmdValid = 1'b1;
		cmd = {wr, code, data};
		do @(posedge linkClk); while (cmdReady !== 1'b1);
		#1;
		cmdValid = 1'b0;
		cmd = ~cmd;
		n = 0;
		do begin
			@(posedge linkClk);
			n++;
		end while (rspValid !== 1'b1 && n < 40);
		r = (rspValid === 1'b1) ? rsp : 'x;
	endtask
endmodule // otfm_host_model

`default_nettype wire

// *** testbench/overtemp_fault_manager_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module overtemp_fault_manager_test;
	import otfm_pkg::*;
	logic        sys_clk, linkClk, rst_n, cmdValid, cmdReady, rspValid;
	otfm_cmd_s   cmd;
	otfm_rsp_s   rsp, r;
	logic        outputEnable, startupDone, nvmReload, dieOverTemp;
	logic [15:0] tempReading;
	logic [7:0]  phaseSelect, softStartRiseMs;
	logic [2:0]  phaseCount;
	logic        converterRun, hostAlert, tempFaultFlag, tempWarnFlag;
	logic [5:0]  ocPhaseStep;
	int          numErrors = 0;
	int          numChecks = 0;
	wire  [3:0]  obs = {tempWarnFlag, tempFaultFlag, hostAlert, converterRun};

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		linkClk = 1'b0;
		#3;
		forever #6 linkClk = ~linkClk;
	end

	otfm_fault_manager #(.MS_CYCLES(20)) u_otfm_fault_manager (
		.sys_clk(sys_clk), .linkClk(linkClk), .rst_n(rst_n), .cmdValid(cmdValid),
		.cmd(cmd), .cmdReady(cmdReady), .rspValid(rspValid), .rsp(rsp),
		.outputEnable(outputEnable), .startupDone(startupDone), .nvmReload(nvmReload),
		.tempReading(tempReading), .phaseSelect(phaseSelect), .phaseCount(phaseCount),
		.softStartRiseMs(softStartRiseMs), .dieOverTemp(dieOverTemp),
		.converterRun(converterRun), .ocPhaseStep(ocPhaseStep), .hostAlert(hostAlert),
		.tempFaultFlag(tempFaultFlag), .tempWarnFlag(tempWarnFlag)
	);
	otfm_host_model u_otfm_host_model (
		.linkClk(linkClk), .cmdReady(cmdReady), .rspValid(rspValid), .rsp(rsp),
		.cmdValid(cmdValid), .cmd(cmd)
	);

	task printVerdict;
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		numChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task sys(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// odd codes follow an idle gap
	task acc(input logic wr, input logic [7:0] code, input logic [15:0] data,
		input logic err = 1'b0, input logic [15:0] exp = 16'h0000);
		u_otfm_host_model.xfer(wr, code, data, code[0] ? 3 : 0, r);
		cmp(16'(r.error), 16'(err), "error");
		if (!wr && !err) cmp(r.data, exp, "data");
		sys(1);
	endtask
	task rd(input logic [7:0] code, input logic [15:0] exp);
		acc(1'b0, code, 16'h0000, 1'b0, exp);
	endtask
	task reEnable;
		outputEnable = 1'b0;
		sys(2);
		outputEnable = 1'b1;
	endtask
	// pin 0 run, 1 alert, 2 fault, 3 warning
	task pin(input int i, input logic e, input int n, input bit stay);
		for (int k = 0; k < n; k++) begin
			sys(1);
			if ((obs[i] === e) != stay) break;
		end
		cmp(16'(obs[i]), 16'(e), "pin");
	endtask
	task oc(input logic [7:0] ph, input logic [15:0] d, input logic [5:0] st, input logic err);
		phaseSelect = ph;
		acc(1'b1, 8'h4A, d, err);
		cmp(16'(ocPhaseStep), 16'(st), "step");
	endtask
	task clear;
		tempReading = 16'h0032;
		acc(1'b1, 8'h03, 16'h0000);
	endtask
	task cool(input logic [15:0] warn, input logic [15:0] mid, input logic [15:0] low);
		acc(1'b1, 8'h51, warn);
		tempReading = 16'h0082;
		pin(0, 1'b0, 20, 1'b0);
		tempReading = mid;
		pin(0, 1'b0, 150, 1'b1);
		tempReading = low;
		pin(0, 1'b1, 400, 1'b0);
		startupDone = 1'b1;
		sys(1);
		startupDone = 1'b0;
		clear();
	endtask

	initial begin
		#500_000;
		numErrors++;
		printVerdict();
	end

	initial begin
		rst_n = 1'b0;
		{outputEnable, startupDone, nvmReload, dieOverTemp} = 4'h0;
		tempReading = 16'h0032;
		phaseSelect = 8'h00;
		phaseCount = 3'h1;
		softStartRiseMs = 8'h02;
		sys(16);
		rst_n = 1'b1;
		sys(10);
		rd(8'h4A, 16'hF0C8);
		rd(8'h4F, 16'h007D);
		rd(8'h50, 16'h0080);
		rd(8'h51, 16'h0069);
		cmp(16'(ocPhaseStep), 16'h003E, "step");
		$display("test reset done");
		acc(1'b0, 8'h20, 16'h0000, 1'b1);
		acc(1'b1, 8'h4F, 16'h07FF, 1'b1);
		rd(8'h4F, 16'h007D);
		rd(8'h7E, 16'h00C0);
		pin(1, 1'b1, 5, 1'b0);
		clear();
		pin(1, 1'b0, 10, 1'b0);
		$display("test refusal done");
		oc(8'h00, 16'h0009, 6'h0A, 1'b0);
		oc(8'h00, 16'h0003, 6'h08, 1'b0);
		oc(8'h00, 16'hF0A1, 6'h2A, 1'b0);
		oc(8'h00, 16'h003F, 6'h2A, 1'b1);
		oc(8'hFF, 16'h0014, 6'h2A, 1'b0);
		oc(8'h00, 16'h003E, 6'h3E, 1'b0);
		phaseCount = 3'h2;
		oc(8'h00, 16'h0064, 6'h3E, 1'b0);
		$display("test current done");
		acc(1'b1, 8'h4F, 16'h00FF);
		acc(1'b1, 8'h51, 16'hF8F3);
		rd(8'h51, 16'hF8F3);
		outputEnable = 1'b1;
		pin(0, 1'b1, 10, 1'b0);
		tempReading = 16'h00C8;
		pin(3, 1'b1, 10, 1'b0);
		pin(2, 1'b0, 30, 1'b1);
		tempReading = 16'h0032;
		nvmReload = 1'b1;
		sys(1);
		nvmReload = 1'b0;
		rd(8'h4A, 16'hF0F8);
		rd(8'h4F, 16'h00A0);
		rd(8'h51, 16'h007A);
		clear();
		$display("test reload done");
		acc(1'b1, 8'h4F, 16'h007D);
		acc(1'b1, 8'h51, 16'h0069);
		tempReading = 16'h0082;
		pin(2, 1'b1, 10, 1'b0);
		pin(0, 1'b0, 10, 1'b0);
		rd(8'h7D, 16'h00C0);
		rd(8'h78, 16'h0004);
		tempReading = 16'h0032;
		pin(0, 1'b0, 100, 1'b1);
		reEnable();
		pin(0, 1'b1, 10, 1'b0);
		clear();
		$display("test latch done");
		acc(1'b1, 8'h50, 16'h00C8);
		cool(16'h005A, 16'h005F, 16'h0055);
		cool(16'h0082, 16'h006E, 16'h0064);
		$display("test cooling done");
		acc(1'b1, 8'h50, 16'h0042);
		tempReading = 16'h0082;
		pin(0, 1'b1, 15, 1'b1);
		pin(0, 1'b0, 80, 1'b0);
		acc(1'b1, 8'h50, 16'h0000);
		reEnable();
		pin(0, 1'b0, 50, 1'b1);
		tempReading = 16'h0032;
		reEnable();
		pin(0, 1'b1, 10, 1'b0);
		tempReading = 16'h0082;
		pin(0, 1'b1, 100, 1'b1);
		dieOverTemp = 1'b1;
		pin(0, 1'b0, 10, 1'b0);
		dieOverTemp = 1'b0;
		pin(0, 1'b1, 10, 1'b0);
		$display("test response done");
		printVerdict();
	end
endmodule // overtemp_fault_manager_test

`default_nettype wire
